//--- common/rio_pkg.sv
package rio_pkg;

    // port geometry
    localparam int unsigned PORT_COUNT = 4;    // number of parallel ports
    localparam int unsigned PORT_WIDTH = 8;    // bits per port
    localparam int unsigned PORT_BITS  = PORT_COUNT * PORT_WIDTH;

    // node address geometry
    localparam int unsigned ADDR_WIDTH = 6;    // address spans 00..3f
    localparam int unsigned FRAME_BITS = 8;    // start, six data, stop

    // reset values
    localparam logic [7:0] OUT_RESET  = 8'h00; // output ports inactive
    localparam logic [5:0] ADDR_RESET = 6'h00; // address before loading

    // clock and timing, times in their own units
    localparam int unsigned CLK_PERIOD_NS = 50;     // 20 mhz sys_clk
    localparam int unsigned PULSE_TIME_NS = 1000;   // indicator low time
    localparam int unsigned WDG_TIME_US   = 1000;   // watchdog timeout
    localparam int unsigned ADDR_BIT_NS   = 1000;   // address stream bit

    // least time, rounded up to whole cycles
    localparam int unsigned PULSE_CYC =
        (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest times, rounded down to whole cycles
    localparam int unsigned WDG_CYC = (WDG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned ADDR_BIT_CYC = ADDR_BIT_NS / CLK_PERIOD_NS;

    // receiver states of the chained address stream
    typedef enum logic [1:0] {
        ADDR_IDLE = 2'b00,   // waiting for a start bit
        ADDR_DATA = 2'b01,   // shifting six address bits, lsb first
        ADDR_STOP = 2'b10    // checking the stop bit
    } rio_addr_state_t;

endpackage

//--- common/rio_pulse_if.sv
`timescale 1ns/1ps
// carries one indicator request and its stretched answer
interface rio_pulse_if;
    logic trig;     // one-cycle request for a pulse
    logic active;   // high while the pulse runs
    modport src (output trig, input active);
    modport gen (input trig, output active);
endinterface

//--- design/rio_pulse_gen.sv
`timescale 1ns/1ps
// stretches a one-cycle request into a fixed-length active window
module rio_pulse_gen #(
    parameter int unsigned COUNT = rio_pkg::PULSE_CYC  // window length
) (
    input wire logic sys_clk,
    input wire logic reset,
    rio_pulse_if.gen pl
);
    import rio_pkg::*;

    localparam int unsigned CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(COUNT);

    // refuse windows too short for the checks below
    if (COUNT < 8) begin : g_bad_count
        $error("pulse window must be at least eight cycles");
    end

    logic [CW-1:0] cnt_q;   // cycles of window left
    logic [CW-1:0] cnt_d;

    // a new request restarts the window, otherwise count down
    always_comb begin
        cnt_d = cnt_q;
        if (pl.trig) begin
            cnt_d = CNT_LOAD;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    // register the count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign pl.active = (cnt_q != '0);

    // window starts the cycle after a request
    a_pulse_start: assert property (@(posedge sys_clk) disable iff (reset)
        pl.trig |=> pl.active && cnt_q == CNT_LOAD)  // [R4]
        else $error("pulse did not start with full length");

    // window only ends after its last counted cycle
    a_pulse_end: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(pl.active) |-> $past(cnt_q) == CW'(1) && !$past(pl.trig))  // [R5]
        else $error("pulse ended early");
endmodule

//--- design/rio_node.sv
`timescale 1ns/1ps
// Operation
// [R1] four eight-bit ports served over the link
// [R2] port direction fixed by configuration pins
// [R3] low invert pin makes port active-low
// [R4] bad frame pulses error indicator low
// [R5] frame for this node pulses indicator
// [R6] watchdog runs only when enabled, expires low
// [R7] action pin picks clear or hold outputs
// [R8] both transmit enables follow transmission together
// [R9] system holds reset over ten clocks running
// [R10] address pins active-low, all low gives 3f
// [R11] chained address: two matches, adopt plus one
// [R12] outputs drive last data, inputs sampled
module rio_node #(
    parameter int unsigned WDG_CYCLES   = rio_pkg::WDG_CYC,   // timeout
    parameter int unsigned PULSE_CYCLES = rio_pkg::PULSE_CYC  // indicator
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic                         port0_invert_n,
    input  wire logic                         port1_invert_n,
    input  wire logic                         port2_invert_n,
    input  wire logic                         port3_invert_n,
    input  wire logic [rio_pkg::PORT_COUNT-1:0] port_is_output,
    input  wire logic [rio_pkg::PORT_BITS-1:0]  port_pins_in,
    output logic      [rio_pkg::PORT_BITS-1:0]  port_pins_out,
    output logic      [rio_pkg::PORT_BITS-1:0]  port_pins_oe,
    input  wire logic                         link_wr_valid,
    input  wire logic [1:0]                   link_wr_port,
    input  wire logic [rio_pkg::PORT_WIDTH-1:0] link_wr_data,
    input  wire logic                         link_sample,
    output logic      [rio_pkg::PORT_BITS-1:0]  link_in_data,
    input  wire logic                         link_frame_to_me,
    input  wire logic                         link_frame_bad,
    input  wire logic                         link_tx_busy,
    output logic                              comm_error_pulse_n,
    output logic                              rx_selected_pulse_n,
    input  wire logic                         watchdog_enable_pin,
    input  wire logic                         watchdog_action_select,
    output logic                              watchdog_expire_n,
    output logic                              tx_drive_enable_n,
    output logic                              tx_drive_enable_p,
    input  wire logic                         addr_load_method,
    input  wire logic                         node_addr_b0_n,
    input  wire logic                         node_addr_b1_n,
    input  wire logic                         node_addr_b2_n,
    input  wire logic                         node_addr_b3_n,
    input  wire logic                         node_addr_b4_n,
    input  wire logic                         node_addr_b5_n,
    output logic                              next_addr_serial_out,
    output logic      [rio_pkg::ADDR_WIDTH-1:0] node_addr,
    output logic                              node_addr_valid
);
    import rio_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    localparam int unsigned WW = $clog2(WDG_CYCLES);
    localparam logic [WW-1:0] WDG_LAST = WW'(WDG_CYCLES - 1);
    localparam int unsigned TW = $clog2(ADDR_BIT_CYC);
    localparam logic [TW-1:0] TICK_LAST = TW'(ADDR_BIT_CYC - 1);

    // refuse counts the logic cannot serve
    if (WDG_CYCLES < 2 || ADDR_BIT_CYC < 2) begin : g_bad_count
        $error("watchdog and bit counts must be at least two");
    end

    // applies a port's polarity to a byte, both ways
    function automatic logic [PORT_WIDTH-1:0] apply_polarity(
        input logic [PORT_WIDTH-1:0] value,
        input logic                  invert_n);
        apply_polarity = invert_n ? value : ~value;
    endfunction

    logic [PORT_COUNT-1:0] invert_n;    // polarity pins as a vector
    assign invert_n = {port3_invert_n, port2_invert_n,
                       port1_invert_n, port0_invert_n};

    // ---------------- watchdog ----------------
    logic [WW-1:0] wdg_cnt_q;   // cycles since last frame
    logic [WW-1:0] wdg_cnt_d;
    logic          wdg_exp_q;   // watchdog has expired
    logic          wdg_exp_d;

    // each frame for this node restarts it; disabled holds it idle
    always_comb begin
        wdg_cnt_d = wdg_cnt_q;
        wdg_exp_d = wdg_exp_q;
        if (!watchdog_enable_pin || link_frame_to_me) begin  // [R6]
            wdg_cnt_d = '0;
            wdg_exp_d = 1'b0;
        end else if (!wdg_exp_q) begin
            if (wdg_cnt_q == WDG_LAST) begin
                wdg_exp_d = 1'b1;                             // [R6]
            end else begin
                wdg_cnt_d = wdg_cnt_q + WW'(1);
            end
        end
    end

    // register the watchdog
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wdg_cnt_q <= '0;
            wdg_exp_q <= 1'b0;
        end else begin
            wdg_cnt_q <= wdg_cnt_d;
            wdg_exp_q <= wdg_exp_d;
        end
    end

    assign watchdog_expire_n = ~wdg_exp_q;

    // ---------------- ports ----------------
    logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] out_q;   // logical output data
    logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] out_d;
    logic [PORT_BITS-1:0] pin_out_d;    // pin levels to drive
    logic [PORT_BITS-1:0] pin_oe_d;     // drive enables
    logic [PORT_BITS-1:0] in_d;         // sampled data for the link
    logic                 force_clr;    // expired watchdog with clear action clears outputs

    assign force_clr = wdg_exp_q && watchdog_action_select;  // [R7]

    // store link data for output ports only; input ports ignore it
    always_comb begin
        out_d = out_q;
        if (link_wr_valid && port_is_output[link_wr_port]) begin  // [R12]
            out_d[link_wr_port] = link_wr_data;
        end
    end

    // per port: pin drive, direction and sampling
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        // drive the newest data with polarity, or inactive on clear
        assign pin_out_d[p*PORT_WIDTH +: PORT_WIDTH] = force_clr ?
            apply_polarity(OUT_RESET, invert_n[p]) :             // [R7]
            apply_polarity(out_d[p], invert_n[p]);                // [R3]
        // whole port drives or whole port listens
        assign pin_oe_d[p*PORT_WIDTH +: PORT_WIDTH] =
            {PORT_WIDTH{port_is_output[p]}};                      // [R2]
        // inputs sampled with polarity; outputs echo their data
        assign in_d[p*PORT_WIDTH +: PORT_WIDTH] = !link_sample ?
            link_in_data[p*PORT_WIDTH +: PORT_WIDTH] :
            port_is_output[p] ? out_q[p] :
            apply_polarity(port_pins_in[p*PORT_WIDTH +: PORT_WIDTH],
                           invert_n[p]);                          // [R12]
    end

    // register port data, pins and samples
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_q         <= {PORT_COUNT{OUT_RESET}};
            port_pins_out <= '0;
            port_pins_oe  <= '0;
            link_in_data  <= '0;
        end else begin
            out_q         <= out_d;                               // [R1]
            port_pins_out <= pin_out_d;
            port_pins_oe  <= pin_oe_d;
            link_in_data  <= in_d;
        end
    end

    // ---------------- indicators and transmit enables ----------------
    rio_pulse_if err_if ();   // error indicator request
    rio_pulse_if sel_if ();   // selection indicator request
    logic        tx_en_q;     // transmission in progress

    assign err_if.trig = link_frame_bad;                          // [R4]
    assign sel_if.trig = link_frame_to_me;                        // [R5]
    assign comm_error_pulse_n  = ~err_if.active;
    assign rx_selected_pulse_n = ~sel_if.active;

    rio_pulse_gen #(.COUNT(PULSE_CYCLES)) u_err_pulse (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pl      (err_if)
    );

    rio_pulse_gen #(.COUNT(PULSE_CYCLES)) u_sel_pulse (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pl      (sel_if)
    );

    // both enables come from one flop so they never disagree
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_en_q <= 1'b0;
        end else begin
            tx_en_q <= link_tx_busy;                              // [R8]
        end
    end

    assign tx_drive_enable_p = tx_en_q;
    assign tx_drive_enable_n = ~tx_en_q;

    // ---------------- node address ----------------
    logic [TW-1:0]         tick_q;       // bit period divider
    logic [TW-1:0]         tick_d;
    logic                  tick;         // one-cycle bit enable
    rio_addr_state_t       rx_st_q;      // stream receiver state
    rio_addr_state_t       rx_st_d;
    logic [2:0]            rx_bit_q;     // data bit index
    logic [2:0]            rx_bit_d;
    logic [ADDR_WIDTH-1:0] rx_sh_q;      // shifted stream value
    logic [ADDR_WIDTH-1:0] rx_sh_d;
    logic [ADDR_WIDTH-1:0] rx_last_q;    // previous received value
    logic [ADDR_WIDTH-1:0] rx_last_d;
    logic                  rx_have_q;    // previous value is held
    logic                  rx_have_d;
    logic                  rx_adopt;     // second matching frame seen
    logic [ADDR_WIDTH-1:0] addr_d;
    logic                  addr_ok_d;
    logic [2:0]            tx_bit_q;     // outgoing frame position
    logic [2:0]            tx_bit_d;
    logic                  so_d;
    logic [ADDR_WIDTH-1:0] pin_addr;     // address pins, active-low

    assign pin_addr = ~{node_addr_b5_n, node_addr_b4_n, node_addr_b3_n,
                        node_addr_b2_n, node_addr_b1_n, node_addr_b0_n};
    assign tick = (tick_q == TICK_LAST);

    // divider, stream receiver and stream sender
    always_comb begin
        tick_d    = tick ? '0 : tick_q + TW'(1);
        rx_st_d   = rx_st_q;
        rx_bit_d  = rx_bit_q;
        rx_sh_d   = rx_sh_q;
        rx_last_d = rx_last_q;
        rx_have_d = rx_have_q;
        rx_adopt  = 1'b0;
        addr_d    = node_addr;
        addr_ok_d = node_addr_valid;
        case (rx_st_q)
            ADDR_IDLE: begin
                if (tick && !node_addr_b0_n) begin  // start bit
                    rx_st_d  = ADDR_DATA;
                    rx_bit_d = 3'h0;
                end
            end
            ADDR_DATA: begin
                if (tick) begin
                    rx_sh_d = {node_addr_b0_n, rx_sh_q[ADDR_WIDTH-1:1]};
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == 3'h5) begin
                        rx_st_d = ADDR_STOP;
                    end
                end
            end
            ADDR_STOP: begin
                if (tick) begin
                    rx_st_d = ADDR_IDLE;
                    if (node_addr_b0_n) begin  // good stop bit
                        if (rx_have_q && rx_last_q == rx_sh_q) begin
                            rx_adopt  = 1'b1;                     // [R11]
                            addr_d    = ADDR_WIDTH'(rx_sh_q + 6'h01);
                            addr_ok_d = 1'b1;
                        end
                        rx_last_d = rx_sh_q;
                        rx_have_d = 1'b1;
                    end
                end
            end
            default: begin
                rx_st_d = ADDR_IDLE;
            end
        endcase
        if (addr_load_method) begin  // pin mode overrides the stream
            addr_d    = pin_addr;                                 // [R10]
            addr_ok_d = 1'b1;
            rx_st_d   = ADDR_IDLE;
            rx_have_d = 1'b0;
        end
        // send own address: start, six bits lsb first, stop
        tx_bit_d = tick ? tx_bit_q + 3'h1 : tx_bit_q;
        case (tx_bit_d)
            3'h0:    so_d = !node_addr_valid;
            3'h7:    so_d = 1'b1;
            default: so_d = node_addr[tx_bit_d - 3'h1];
        endcase
    end

    // register the address logic
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick_q               <= '0;
            rx_st_q              <= ADDR_IDLE;
            rx_bit_q             <= 3'h0;
            rx_sh_q              <= ADDR_RESET;
            rx_last_q            <= ADDR_RESET;
            rx_have_q            <= 1'b0;
            node_addr            <= ADDR_RESET;
            node_addr_valid      <= 1'b0;
            tx_bit_q             <= 3'h0;
            next_addr_serial_out <= 1'b1;
        end else begin
            tick_q               <= tick_d;
            rx_st_q              <= rx_st_d;
            rx_bit_q             <= rx_bit_d;
            rx_sh_q              <= rx_sh_d;
            rx_last_q            <= rx_last_d;
            rx_have_q            <= rx_have_d;
            node_addr            <= addr_d;
            node_addr_valid      <= addr_ok_d;
            tx_bit_q             <= tx_bit_d;
            next_addr_serial_out <= so_d;
        end
    end

    // ---------------- checks ----------------
    a_tx_enable_pair: assert property (link_tx_busy |=>
        tx_drive_enable_p && !tx_drive_enable_n)  // [R8]
        else $error("transmit enables not both asserted");
    a_err_pulse_len: assert property (link_frame_bad |=>
        !comm_error_pulse_n [*8])  // [R4]
        else $error("error indicator too short");
    a_sel_pulse_len: assert property (link_frame_to_me |=>
        !rx_selected_pulse_n [*8])  // [R5]
        else $error("selection indicator too short");
    a_wdg_idle_off: assert property (!watchdog_enable_pin |=>
        watchdog_expire_n && wdg_cnt_q == '0)  // [R6]
        else $error("disabled watchdog not idle");
    a_wdg_trip_time: assert property (watchdog_enable_pin &&
        !link_frame_to_me && wdg_cnt_q == WDG_LAST |=> !watchdog_expire_n)  // [R6]
        else $error("watchdog did not expire on time");
    a_wdg_clear_out: assert property (force_clr |=>
        port_pins_out[PORT_WIDTH-1:0] ==
        {PORT_WIDTH{!$past(port0_invert_n)}})  // [R7]
        else $error("expired watchdog did not clear outputs");
    a_port_write_drive: assert property (link_wr_valid &&
        link_wr_port == 2'h0 && port_is_output[0] && !force_clr |=>
        port_pins_out[PORT_WIDTH-1:0] == ($past(port0_invert_n) ?
        $past(link_wr_data) : ~$past(link_wr_data)))  // [R3]
        else $error("port write not driven with polarity");
    a_port_dir_oe: assert property ($past(port_is_output[1]) == 1'b0 |->
        port_pins_oe[2*PORT_WIDTH-1:PORT_WIDTH] == '0)  // [R2]
        else $error("input port is driven");
    a_addr_pin_mode: assert property (addr_load_method |=>
        node_addr == ~$past({node_addr_b5_n, node_addr_b4_n,
        node_addr_b3_n, node_addr_b2_n, node_addr_b1_n, node_addr_b0_n}))  // [R10]
        else $error("pin address not taken active-low");
    a_addr_chain_adopt: assert property (!addr_load_method &&
        $changed(node_addr) && !$past(addr_load_method) |->
        $past(rx_adopt) && node_addr == $past(rx_sh_q) + 6'h01)  // [R11]
        else $error("chained address changed without two matches");
endmodule

//--- sim/rio_ctrl_model.sv
`timescale 1ns/1ps
// controller side of the link: strobes change only at falling edges
module rio_ctrl_model (
    input  wire logic       sys_clk,
    output logic            wr_valid,
    output logic [1:0]      wr_port,
    output logic [7:0]      wr_data,
    output logic            sample,
    output logic            to_me,
    output logic            bad,
    output logic            tx_busy
);
    // all strobes idle from time zero
    initial begin
        wr_valid = 1'b0;
        wr_port  = 2'h0;
        wr_data  = 8'h00;
        sample   = 1'b0;
        to_me    = 1'b0;
        bad      = 1'b0;
        tx_busy  = 1'b0;
    end
    // one port byte, strobe held for a single edge
    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        @(negedge sys_clk);
        wr_valid = 1'b1;
        wr_port  = p;
        wr_data  = d;
        @(negedge sys_clk);
        wr_valid = 1'b0;
        wr_data  = ~d;    // released data does not linger
    endtask
    // one-edge event: 0 sample, 1 own frame, 2 bad frame
    task automatic ev(input int k);
        @(negedge sys_clk);
        if (k == 0) sample = 1'b1;
        if (k == 1) to_me = 1'b1;
        if (k == 2) bad = 1'b1;
        @(negedge sys_clk);
        sample = 1'b0;
        to_me  = 1'b0;
        bad    = 1'b0;
    endtask
    // serial transmitter activity level
    task automatic busy(input logic b);
        @(negedge sys_clk);
        tx_busy = b;
    endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
// self-checking bench for the remote port node
module tb;
    import rio_pkg::*;
    localparam int unsigned WDG = 16;  // short watchdog for sim
    localparam int unsigned PLS = 8;   // short indicator window
    logic        sys_clk, reset;
    logic [3:0]  inv_n, dir;           // polarity and direction pins
    logic [31:0] p_in, p_out, p_oe, in_data;
    logic        wr_valid, sample, to_me, bad, busy;
    logic [1:0]  wr_port;
    logic [7:0]  wr_data;
    logic        err_n, sel_n, wdg_en, wdg_act, wdg_n;
    logic        tx_n, tx_p, alm, nso, aval;
    logic [5:0]  a_n, addr;
    logic [7:0]  st [4];               // logical bytes held per port
    logic [7:0]  d;
    int          fail_count, n_checks, cnt;
    // free-running 20 mhz clock
    always #25 sys_clk = ~sys_clk;
    rio_ctrl_model cm (.sys_clk(sys_clk), .wr_valid(wr_valid),
        .wr_port(wr_port), .wr_data(wr_data), .sample(sample),
        .to_me(to_me), .bad(bad), .tx_busy(busy));
    rio_node #(.WDG_CYCLES(WDG), .PULSE_CYCLES(PLS)) DUT (
        .sys_clk(sys_clk), .reset(reset), .port0_invert_n(inv_n[0]),
        .port1_invert_n(inv_n[1]), .port2_invert_n(inv_n[2]),
        .port3_invert_n(inv_n[3]), .port_is_output(dir),
        .port_pins_in(p_in), .port_pins_out(p_out), .port_pins_oe(p_oe),
        .link_wr_valid(wr_valid), .link_wr_port(wr_port),
        .link_wr_data(wr_data), .link_sample(sample),
        .link_in_data(in_data), .link_frame_to_me(to_me),
        .link_frame_bad(bad), .link_tx_busy(busy),
        .comm_error_pulse_n(err_n), .rx_selected_pulse_n(sel_n),
        .watchdog_enable_pin(wdg_en), .watchdog_action_select(wdg_act),
        .watchdog_expire_n(wdg_n), .tx_drive_enable_n(tx_n),
        .tx_drive_enable_p(tx_p), .addr_load_method(alm),
        .node_addr_b0_n(a_n[0]), .node_addr_b1_n(a_n[1]),
        .node_addr_b2_n(a_n[2]), .node_addr_b3_n(a_n[3]),
        .node_addr_b4_n(a_n[4]), .node_addr_b5_n(a_n[5]),
        .next_addr_serial_out(nso), .node_addr(addr),
        .node_addr_valid(aval));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // pin level of a logical byte under a port's polarity pin
    function automatic logic [7:0] pol(input logic [7:0] v, input logic n);
        return n ? v : ~v;
    endfunction
    // expected pins of output ports, zero elsewhere
    function automatic logic [31:0] e_out(input logic kill);
        logic [31:0] r;
        r = '0;
        for (int p = 0; p < 4; p++)
            if (dir[p]) r[8*p +: 8] = pol(kill ? 8'h00 : st[p], inv_n[p]);
        return r;
    endfunction
    // drive enables expected from direction pins
    function automatic logic [31:0] e_oe();
        logic [31:0] r;
        for (int p = 0; p < 4; p++) r[8*p +: 8] = {8{dir[p]}};
        return r;
    endfunction
    // sampled logical values: pins for inputs, stored bytes for outputs
    function automatic logic [31:0] e_in();
        logic [31:0] r;
        for (int p = 0; p < 4; p++)
            r[8*p +: 8] = dir[p] ? st[p] : pol(p_in[8*p +: 8], inv_n[p]);
        return r;
    endfunction
    // count falling edges an indicator stays low after its event
    task automatic pulse(input int k);
        cm.ev(k);
        cnt = 0;
        while ((k == 1 ? sel_n : err_n) === 1'b0 && cnt < 50) begin
            cnt++;
            @(negedge sys_clk);
        end
        chk(cnt, PLS);
    endtask
    // outputs while reset is held
    task automatic rst_chk;
        chk(p_out, 32'h0);
        chk(p_oe, 32'h0);
        chk(in_data, 32'h0);
        chk({err_n, sel_n, wdg_n, tx_p, tx_n}, 5'h1d);
        chk({nso, aval, addr}, 8'h80);
    endtask
    // one chained address frame on b0: start, six bits lsb first, stop
    task automatic frame(input logic [5:0] v);
        logic [7:0] f;
        f = {1'b1, v, 1'b0};
        for (int b = 0; b < 8; b++) begin
            a_n[0] = f[b];
            repeat (ADDR_BIT_CYC) @(negedge sys_clk);
        end
    endtask
    // hang guard
    initial begin
        #(50 * 100000);
        fail_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        void'($urandom(32'h4ac8));
        sys_clk = 1'b0;
        reset   = 1'b1;
        p_in    = '0;
        dir     = 4'hf;
        inv_n   = 4'hf;
        wdg_en  = 1'b0;
        wdg_act = 1'b0;
        alm     = 1'b1;
        a_n     = 6'h3f;
        for (int p = 0; p < 4; p++) st[p] = 8'h00;
        repeat (2) @(negedge sys_clk);
        rst_chk();
        reset = 1'b0;
        // ports: all out, all in, then random mixes
        for (int r = 0; r < 8; r++) begin
            dir   = r == 0 ? 4'hf : r == 1 ? 4'h0 : 4'($urandom);
            inv_n = r == 0 ? 4'h0 : 4'($urandom);
            for (int p = 0; p < 4; p++) begin
                d = 8'($urandom);
                cm.wr(2'(p), d);
                if (dir[p]) st[p] = d;
                chk(p_out & e_oe(), e_out(1'b0));
            end
            chk(p_oe, e_oe());
            p_in = $urandom;
            cm.ev(0);
            chk(in_data, e_in());
        end
        pulse(2);
        pulse(1);
        // watchdog expiry with outputs forced inactive
        wdg_act = 1'b1;
        wdg_en  = 1'b1;
        cm.ev(1);
        repeat (WDG - 1) @(negedge sys_clk);
        chk(wdg_n, 1'b1);
        @(negedge sys_clk);
        chk(wdg_n, 1'b0);
        @(negedge sys_clk);
        chk(p_out & e_oe(), e_out(1'b1));
        cm.ev(1);
        @(negedge sys_clk);
        chk(wdg_n, 1'b1);
        chk(p_out & e_oe(), e_out(1'b0));
        // expiry with the hold action leaves outputs alone
        wdg_act = 1'b0;
        repeat (WDG + 2) @(negedge sys_clk);
        chk(wdg_n, 1'b0);
        chk(p_out & e_oe(), e_out(1'b0));
        wdg_en = 1'b0;
        repeat (2 * WDG) @(negedge sys_clk);
        chk(wdg_n, 1'b1);
        // transmit enables move together, opposite levels
        cm.busy(1'b1);
        @(negedge sys_clk);
        chk({tx_p, tx_n}, 2'b10);
        cm.busy(1'b0);
        @(negedge sys_clk);
        chk({tx_p, tx_n}, 2'b01);
        // address pins, all-low corner first, last leaves b0 idle high
        for (int i = 0; i < 5; i++) begin
            a_n = i == 0 ? 6'h00 : i == 4 ? 6'h01 : 6'($urandom);
            repeat (2) @(negedge sys_clk);
            chk({aval, addr}, {1'b1, ~a_n});
        end
        // chained address: a lone frame, then two matching ones
        alm = 1'b0;
        frame(6'h15);
        frame(6'h37);
        chk({aval, addr}, {1'b1, 6'h3e});
        frame(6'h37);
        chk({aval, addr}, {1'b1, 6'h38});
        // own address streamed out: find the start bit, sample mid-bit
        repeat (ADDR_BIT_CYC) @(negedge sys_clk);
        cnt = 0;
        while (nso !== 1'b1 && cnt < 200) begin
            cnt++;
            @(negedge sys_clk);
        end
        while (nso !== 1'b0 && cnt < 400) begin
            cnt++;
            @(negedge sys_clk);
        end
        repeat (ADDR_BIT_CYC / 2) @(negedge sys_clk);
        for (int b = 0; b < 8; b++) begin
            d[b] = nso;
            repeat (ADDR_BIT_CYC) @(negedge sys_clk);
        end
        chk(d, {1'b1, 6'h38, 1'b0});
        // mid-run reset held long with the clock running
        reset = 1'b1;
        repeat (11) @(negedge sys_clk);
        rst_chk();
        reset = 1'b0;
        tally_and_finish();
    end
endmodule
